// ---- rtl/bmp_pkg.sv ----
package bmp_pkg;

    // ==========================================================
    // Register byte addresses on the Avalon slave
    // ==========================================================
    localparam logic [3:0] ADDR_CTRL1 = 4'h0; // First control register
    localparam logic [3:0] ADDR_CTRL3 = 4'h4; // Third control register
    localparam logic [3:0] ADDR_STATUS = 4'h8; // Status, retry and limit flags clear on read

    // ==========================================================
    // Field positions
    // ==========================================================
    localparam int C1_SLEW_LSB = 0; // Slew select field, two bits
    localparam int C1_FPWM = 2; // Forced PWM bit
    localparam int C1_SSC = 3; // Spread spectrum enable
    localparam int C1_DISCH = 4; // Output discharge enable
    localparam int C1_SWITCHING_ENABLE_BIT = 5; // Switching enable bit
    localparam int C1_HIC = 6; // Overload retry enable
    localparam int C3_DROOP = 0; // Load droop enable
    localparam int ST_HIC = 0; // Overload retry flag
    localparam int ST_CURRENT_LIMIT_FLAG = 1; // Current limit flag
    localparam int ST_UV = 2; // Live supply undervoltage
    localparam int ST_OV = 3; // Live supply overvoltage
    localparam int ST_PG = 4; // Live power good
    localparam int ST_RUN = 5; // Live switching state

    // ==========================================================
    // Reset values
    // ==========================================================
    localparam logic [7:0] CTRL1_RESET = 8'h32; // Slew 10, discharge on, switching on
    localparam logic [7:0] CTRL3_RESET = 8'h00; // Droop off

    // ==========================================================
    // Slew codes and rates in uV/us
    // ==========================================================
    localparam logic [1:0] SLEW_FAST = 2'h0;
    localparam logic [1:0] SLEW_MID = 2'h1;
    localparam logic [1:0] SLEW_SLOW = 2'h2;
    localparam logic [1:0] SLEW_SLOWEST = 2'h3;
    localparam logic [13:0] RATE_FAST = 14'h2710; // 10 mV/us
    localparam logic [13:0] RATE_MID = 14'h1388; // 5 mV/us
    localparam logic [13:0] RATE_SLOW = 14'h04E2; // 1.25 mV/us
    localparam logic [13:0] RATE_SLOWEST = 14'h01F4; // 0.5 mV/us

    // ==========================================================
    // Timing, clock is 20 MHz
    // ==========================================================
    localparam int CLK_MHZ = 20;
    localparam int PAUSE_US = 128; // Retry pause
    localparam int PAUSE_CYCLES = PAUSE_US * CLK_MHZ;
    localparam int PG_DEGLITCH_US = 40; // Power good rising deglitch
    localparam int PG_CYCLES = PG_DEGLITCH_US * CLK_MHZ;
    localparam int HIC_RUN_CYCLES = 32; // Limited cycles before a pause
    localparam int CURRENT_LIMIT_FLAG_RUN_CYCLES = 4; // Limited cycles before the flag
    localparam logic signed [4:0] SSC_SPAN_PCT = 5'sh0A; // Triangle peak, percent

    // ==========================================================
    // Sequencer states, one-hot
    // ==========================================================
    typedef enum logic [3:0] {
        BMP_OFF = 4'h1,
        BMP_START = 4'h2,
        BMP_RUN = 4'h4,
        BMP_PAUSE = 4'h8
    } bmp_state_e;

    // Slew rate for a slew select code
    function automatic logic [13:0] bmp_slew_rate(input logic [1:0] code);
        logic [13:0] rate;
        rate = RATE_SLOW;
        unique case (code)
            SLEW_FAST: rate = RATE_FAST;
            SLEW_MID: rate = RATE_MID;
            SLEW_SLOW: rate = RATE_SLOW;
            SLEW_SLOWEST: rate = RATE_SLOWEST;
        endcase
        return rate;
    endfunction

endpackage

// ---- rtl/bmp_timer.sv ----
`timescale 1ns/1ps
// Down counter: load restarts it, done when it reaches zero
module bmp_timer
    import bmp_pkg::*;
#(
    parameter int LEN = PAUSE_CYCLES,
    parameter int W = 12
)
(
    input wire logic clock,
    input wire logic rst,
    input wire logic load,
    output logic done
);

    // ==========================================================
    // State
    // ==========================================================
    typedef struct packed {
        logic [W-1:0] cnt; // Cycles still to wait
    } bmp_timer_s;

    bmp_timer_s st; // Registered state
    bmp_timer_s next_st; // Next state

    // Reload on request, otherwise count down to zero and stay
    always_comb
    begin
        next_st = st;
        if (load)
        begin
            next_st.cnt = W'(LEN);
        end
        else if (st.cnt != '0)
        begin
            next_st.cnt = st.cnt - 1'b1;
        end
    end

    // Reset loads the full length so done is low out of reset
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            st.cnt <= W'(LEN);
        end
        else
        begin
            st <= next_st;
        end
    end

    assign done = (st.cnt == '0);

endmodule

// ---- rtl/bmp_ctrl.sv ----
`timescale 1ns/1ps
module bmp_ctrl
    import bmp_pkg::*;
#(
    parameter int PAUSE_LEN = PAUSE_CYCLES,
    parameter int PG_LEN = PG_CYCLES,
    parameter int TIMER_W = 12,
    parameter int HIC_COUNT = HIC_RUN_CYCLES,
    parameter int CURRENT_LIMIT_FLAG_COUNT = CURRENT_LIMIT_FLAG_RUN_CYCLES,
    parameter int CNT_W = 6
)
(
    input wire logic clock,
    input wire logic rst,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic en_pin,
    input wire logic mode_pwm_level,
    input wire logic sync_clock_valid,
    input wire logic supply_uv,
    input wire logic supply_ov,
    input wire logic thermal_shutdown,
    input wire logic sw_cycle,
    input wire logic hs_over_limit,
    input wire logic ls_below_limit,
    input wire logic pg_window_ok,
    output logic switching_active,
    output logic hs_gate_en,
    output logic ls_force_on,
    output logic soft_start_req,
    output logic forced_pwm,
    output logic sync_align,
    output logic ssc_active,
    output logic signed [4:0] ssc_trim_pct,
    output logic discharge_on,
    output logic droop_enable,
    output logic [13:0] slew_rate_uv_per_us,
    output logic power_good
);

    // ==========================================================
    // State
    // ==========================================================
    typedef struct packed {
        logic [7:0] ctrl1; // First control register
        logic [7:0] ctrl3; // Third control register
        bmp_state_e state; // Sequencer
        logic [CNT_W-1:0] consec; // Consecutive limited cycles
        logic cyc_lim; // Limit seen in the running cycle
        logic hs_block; // High side held off by the limit
        logic ever_en; // Device enabled at least once
        logic hic_flag; // Overload retry flag
        logic current_limit_flag_flag; // Current limit flag
        logic ack; // Bus answer phase
        logic [7:0] rdata; // Captured read data
        logic signed [4:0] trim; // Frequency trim in percent
        logic trim_up; // Triangle direction
        logic fpwm; // Forced PWM output
        logic sync; // Sync alignment output
        logic spread_spectrum_clocking; // Spread spectrum output
        logic disch; // Discharge output
        logic hs_on; // High side gate enable
        logic ls_on; // Low side forced on
        logic [13:0] slew; // Slew rate output
        logic pg; // Power good output
    } bmp_ctrl_s;

    bmp_ctrl_s st; // Registered state
    bmp_ctrl_s next_st; // Next state

    logic bus_req; // Read or write pending
    logic fault; // Any reason to stop switching except the retry pause
    logic fpwm_req; // Forced PWM asked by pin or bit
    logic overload_now; // Overload still present
    logic pg_raw; // Power good before deglitch
    logic pg_done; // Deglitch time elapsed
    logic pause_done; // Retry pause elapsed
    logic pause_load; // Entering the retry pause
    logic sw_now; // Switching in the current state
    logic sw_next; // Switching in the next state

    assign bus_req = avs_read | avs_write;
    assign fault = ~en_pin | ~st.ctrl1[C1_SWITCHING_ENABLE_BIT] | supply_uv | supply_ov | thermal_shutdown;
    assign fpwm_req = mode_pwm_level | st.ctrl1[C1_FPWM];
    assign overload_now = hs_over_limit | st.cyc_lim | (st.consec != '0) | (st.state == BMP_PAUSE);
    assign pg_raw = pg_window_ok & (st.state == BMP_RUN) & ~fault;
    assign sw_now = (st.state == BMP_START) | (st.state == BMP_RUN);
    assign sw_next = (next_st.state == BMP_START) | (next_st.state == BMP_RUN);
    assign pause_load = (next_st.state == BMP_PAUSE) & (st.state != BMP_PAUSE);

    // ==========================================================
    // Timers on this clock, which keeps running while switching stops
    // ==========================================================
    bmp_timer #(
        .LEN(PAUSE_LEN),
        .W(TIMER_W)
    ) u_pause (
        .clock(clock),
        .rst(rst),
        .load(pause_load),
        .done(pause_done)
    );

    // Held in reload while raw is low, so only the rising edge waits
    bmp_timer #(
        .LEN(PG_LEN),
        .W(TIMER_W)
    ) u_pg (
        .clock(clock),
        .rst(rst),
        .load(~pg_raw),
        .done(pg_done)
    );

    // ==========================================================
    // Next state
    // ==========================================================
    always_comb
    begin
        logic [7:0] status_v;
        status_v = '0;
        next_st = st;
        status_v[ST_HIC] = st.hic_flag;
        status_v[ST_CURRENT_LIMIT_FLAG] = st.current_limit_flag_flag;
        status_v[ST_UV] = supply_uv;
        status_v[ST_OV] = supply_ov;
        status_v[ST_PG] = st.pg;
        status_v[ST_RUN] = sw_now;

        // Bus: one wait cycle, data captured before the answer
        next_st.ack = bus_req & ~st.ack;
        if (bus_req & ~st.ack)
        begin
            unique case (avs_address)
                ADDR_CTRL1: next_st.rdata = st.ctrl1;
                ADDR_CTRL3: next_st.rdata = st.ctrl3;
                ADDR_STATUS: next_st.rdata = status_v;
                default: next_st.rdata = '0; // Unmapped reads zero
            endcase
        end
        // Writes land at the answer edge, unmapped ones are dropped
        if (avs_write & st.ack & avs_byteenable[0])
        begin
            if (avs_address == ADDR_CTRL1)
            begin
                next_st.ctrl1 = {1'b0, avs_writedata[6:0]};
            end
            else if (avs_address == ADDR_CTRL3)
            begin
                next_st.ctrl3 = {7'h00, avs_writedata[C3_DROOP]};
            end
        end

        // Slew rate follows the field for every setpoint move
        next_st.slew = bmp_slew_rate(st.ctrl1[C1_SLEW_LSB +: 2]);

        // Mode selection; a sync clock wins over a low mode pin
        next_st.fpwm = fpwm_req | sync_clock_valid;
        next_st.sync = sync_clock_valid;
        next_st.spread_spectrum_clocking = st.ctrl1[C1_SSC] & fpwm_req & ~sync_clock_valid;

        // Triangle trim steps one percent per switching cycle
        if (!st.spread_spectrum_clocking)
        begin
            next_st.trim = '0;
            next_st.trim_up = 1'b1;
        end
        else if (sw_cycle)
        begin
            if (st.trim_up && st.trim >= SSC_SPAN_PCT)
            begin
                next_st.trim_up = 1'b0;
                next_st.trim = st.trim - 5'sh01;
            end
            else if (!st.trim_up && st.trim <= -SSC_SPAN_PCT)
            begin
                next_st.trim_up = 1'b1;
                next_st.trim = st.trim + 5'sh01;
            end
            else
            begin
                next_st.trim = st.trim_up ? st.trim + 5'sh01 : st.trim - 5'sh01;
            end
        end

        // Discharge armed only after a first enable
        if (en_pin & st.ctrl1[C1_SWITCHING_ENABLE_BIT])
        begin
            next_st.ever_en = 1'b1;
        end
        next_st.disch = st.ctrl1[C1_DISCH] & st.ever_en & fault;

        // Limit latch releases only below the low-side threshold
        next_st.hs_block = hs_over_limit | (st.hs_block & ~ls_below_limit);

        // Sequencer; a fault wins from any state
        unique case (st.state)
            BMP_OFF:
            begin
                if (!fault)
                begin
                    next_st.state = BMP_START;
                end
            end
            BMP_START:
            begin
                next_st.state = BMP_RUN;
            end
            BMP_RUN:
            begin
                next_st.state = BMP_RUN;
            end
            BMP_PAUSE:
            begin
                if (pause_done)
                begin
                    next_st.state = BMP_START;
                end
            end
            default:
            begin
                next_st.state = BMP_OFF; // Illegal code
            end
        endcase

        // Count limited cycles, closed at each cycle boundary
        if (st.state != BMP_RUN)
        begin
            next_st.consec = '0;
            next_st.cyc_lim = 1'b0;
        end
        else if (sw_cycle)
        begin
            next_st.cyc_lim = 1'b0;
            if (st.cyc_lim | hs_over_limit)
            begin
                if (st.consec != '1)
                begin
                    next_st.consec = st.consec + 1'b1;
                end
            end
            else
            begin
                next_st.consec = '0;
            end
        end
        else
        begin
            next_st.cyc_lim = st.cyc_lim | hs_over_limit;
        end

        // Clear on read only with the overload gone
        if (avs_read & st.ack & (avs_address == ADDR_STATUS) & ~overload_now)
        begin
            next_st.hic_flag = 1'b0;
            next_st.current_limit_flag_flag = 1'b0;
        end
        // Sets are applied last so they win over a clear
        if (st.state == BMP_RUN && st.ctrl1[C1_HIC] && next_st.consec >= CNT_W'(HIC_COUNT))
        begin
            next_st.state = BMP_PAUSE;
            next_st.consec = '0;
            next_st.hic_flag = 1'b1;
        end
        if (!st.ctrl1[C1_HIC] && next_st.consec >= CNT_W'(CURRENT_LIMIT_FLAG_COUNT))
        begin
            next_st.current_limit_flag_flag = 1'b1;
        end
        if (fault)
        begin
            next_st.state = BMP_OFF;
        end

        // Gate drive follows next state and limit latch
        next_st.hs_on = sw_next & ~next_st.hs_block;
        next_st.ls_on = sw_next & next_st.hs_block;
        next_st.pg = pg_raw & pg_done;
    end

    // ==========================================================
    // Registers
    // ==========================================================
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            st <= '0;
            st.ctrl1 <= CTRL1_RESET;
            st.ctrl3 <= CTRL3_RESET;
            st.state <= BMP_OFF;
            st.trim_up <= 1'b1;
            st.slew <= RATE_SLOW;
        end
        else
        begin
            st <= next_st;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    assign avs_waitrequest = bus_req & ~st.ack;
    assign avs_readdata = {24'h00_0000, st.rdata};
    assign switching_active = sw_now;
    assign soft_start_req = (st.state == BMP_START);
    assign hs_gate_en = st.hs_on;
    assign ls_force_on = st.ls_on;
    assign forced_pwm = st.fpwm;
    assign sync_align = st.sync;
    assign ssc_active = st.spread_spectrum_clocking;
    assign ssc_trim_pct = st.trim;
    assign discharge_on = st.disch;
    assign droop_enable = st.ctrl3[C3_DROOP];
    assign slew_rate_uv_per_us = st.slew;
    assign power_good = st.pg;

    // ==========================================================
    // Checks
    // ==========================================================
    logic [TIMER_W-1:0] pause_run; // Cycles spent in the pause
    logic [TIMER_W-1:0] raw_run; // Cycles with raw power good high

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            pause_run <= '0;
            raw_run <= '0;
        end
        else
        begin
            pause_run <= (st.state == BMP_PAUSE) ? pause_run + 1'b1 : '0;
            raw_run <= !pg_raw ? '0 : (raw_run == '1 ? raw_run : raw_run + 1'b1);
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    sequence s_run_to_pause;
        (st.state == BMP_RUN) ##1 (st.state == BMP_PAUSE);
    endsequence

    chk_slew_rate_map: assert property (##1 slew_rate_uv_per_us == bmp_slew_rate($past(st.ctrl1[1:0])))
        else $error("slew rate does not match slew code");
    chk_pwm_or_sync: assert property (##1 forced_pwm == $past(mode_pwm_level | st.ctrl1[C1_FPWM] | sync_clock_valid))
        else $error("forced pwm is not pin or bit or sync");
    chk_ssc_gating: assert property (ssc_active |-> !$past(sync_clock_valid) && $past(st.ctrl1[C1_SSC]))
        else $error("spread spectrum active without its conditions");
    chk_ssc_span: assert property (ssc_trim_pct <= SSC_SPAN_PCT && ssc_trim_pct >= -SSC_SPAN_PCT)
        else $error("spread spectrum trim beyond ten percent");
    chk_disch_armed: assert property (discharge_on |-> $past(st.ever_en && st.ctrl1[C1_DISCH]))
        else $error("discharge before first enable or while disabled");
    chk_uv_stops: assert property (supply_uv |=> !switching_active && !hs_gate_en)
        else $error("switching continued under undervoltage");
    chk_cbc_limit: assert property (hs_over_limit |=> !hs_gate_en)
        else $error("high side on after limit");
    chk_pause_length: assert property ((st.state == BMP_PAUSE) && pause_done && !fault |-> pause_run == PAUSE_LEN)
        else $error("retry pause has wrong length");
    chk_pause_flag: assert property (s_run_to_pause |-> st.hic_flag && !switching_active)
        else $error("pause entered without retry flag");
    chk_flag_clear: assert property ($fell(st.current_limit_flag_flag) |-> $past(avs_read && st.ack && !overload_now))
        else $error("limit flag cleared without qualified read");
    chk_pg_deglitch: assert property ($rose(power_good) |-> raw_run >= PG_LEN)
        else $error("power good rose before deglitch");

endmodule

// ---- verification/bmp_stage_model.sv ----
`timescale 1ns/1ps
// ==========================================
// Power stage stand-in: cycle ticks, comparators
// ==========================================
module bmp_stage_model
(
    input wire logic clock,
    input wire logic rst,
    input wire logic overload,
    output logic sw_cycle,
    output logic hs_over_limit,
    output logic ls_below_limit,
    output logic pg_window_ok
);
    logic [1:0] phase; // Four clocks per switching cycle

    // Free running phase, keeps limit counts short
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            phase <= 2'h0;
        else
            phase <= phase + 2'h1;
    end

    assign sw_cycle = (phase == 2'h3);
    // Overload holds peak current high and the valley never drops
    assign hs_over_limit = overload;
    assign ls_below_limit = !overload;
    assign pg_window_ok = !overload;
endmodule

// ---- verification/bmp_ctrl_bench.sv ----
`timescale 1ns/1ps
module bmp_ctrl_bench;
    import bmp_pkg::*;
    // ==========================================
    // Stimulus and observed signals
    // ==========================================
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic en_pin = 1'b0;
    logic mode_pwm_level = 1'b0;
    logic sync_clock_valid = 1'b0;
    logic supply_uv = 1'b0;
    logic supply_ov = 1'b0;
    logic thermal_shutdown = 1'b0;
    logic overload = 1'b0;
    logic sw_cycle, hs_over_limit, ls_below_limit, pg_window_ok, switching_active, hs_gate_en, ls_force_on;
    logic soft_start_req, forced_pwm, sync_align, ssc_active, discharge_on, droop_enable, power_good;
    logic signed [4:0] ssc_trim_pct;
    logic [13:0] slew_rate_uv_per_us;
    logic [31:0] q;
    int num_errors = 0;
    int cmp_count = 0;

    // Short pause and deglitch keep the run brief
    bmp_ctrl #(.PAUSE_LEN(8), .PG_LEN(8)) bmp_ctrl_i (.clock(clock), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .en_pin(en_pin),
        .mode_pwm_level(mode_pwm_level), .sync_clock_valid(sync_clock_valid), .supply_uv(supply_uv),
        .supply_ov(supply_ov), .thermal_shutdown(thermal_shutdown), .sw_cycle(sw_cycle), .hs_over_limit(hs_over_limit),
        .ls_below_limit(ls_below_limit), .pg_window_ok(pg_window_ok), .switching_active(switching_active),
        .hs_gate_en(hs_gate_en), .ls_force_on(ls_force_on), .soft_start_req(soft_start_req),
        .forced_pwm(forced_pwm), .sync_align(sync_align), .ssc_active(ssc_active), .ssc_trim_pct(ssc_trim_pct),
        .discharge_on(discharge_on), .droop_enable(droop_enable), .slew_rate_uv_per_us(slew_rate_uv_per_us),
        .power_good(power_good));
    bmp_stage_model bmp_stage_model_i (.clock(clock), .rst(rst), .overload(overload), .sw_cycle(sw_cycle),
        .hs_over_limit(hs_over_limit), .ls_below_limit(ls_below_limit), .pg_window_ok(pg_window_ok));

    // ==========================================
    // Shared tasks
    // ==========================================
    task automatic conclude();
        if (num_errors == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One Avalon access, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
        int i;
        @(posedge clock);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= {24'h00_0000, d};
        for (i = 0; i < 20; i++)
        begin
            @(posedge clock);
            if (avs_waitrequest === 1'b0)
                break;
        end
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (i == 20)
        begin
            num_errors++;
            conclude();
        end
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge clock);
    endtask

    // Bounded wait for the run state to reach a level
    task automatic wait_run(input logic lvl);
        int i;
        for (i = 0; i < 300 && switching_active !== lvl; i++)
            @(posedge clock);
        chk(32'(switching_active), 32'(lvl));
        if (i == 300)
            conclude();
    endtask

    // ==========================================
    // Scenarios
    // ==========================================
    task automatic scen_regs();
        logic [13:0] rate [4] = '{RATE_FAST, RATE_MID, RATE_SLOW, RATE_SLOWEST};
        bus(0, ADDR_CTRL1, 8'h00);
        chk(q, 32'h0000_0032);
        chk(32'(slew_rate_uv_per_us), 32'(RATE_SLOW));
        bus(0, 4'hC, 8'h00);
        chk(q, 32'h0000_0000);
        bus(1, ADDR_CTRL3, 8'h01);
        cycles(2);
        chk(32'(droop_enable), 32'h0000_0001);
        for (int c = 0; c < 4; c++)
        begin
            bus(1, ADDR_CTRL1, 8'h30 | 8'(c));
            cycles(2);
            chk(32'(slew_rate_uv_per_us), 32'(rate[c]));
        end
        bus(1, ADDR_CTRL1, 8'h32);
    endtask

    task automatic scen_discharge();
        cycles(3);
        chk(32'(discharge_on), 32'h0000_0000);
        en_pin <= 1'b1;
        cycles(25);
        chk({switching_active, power_good}, 32'h0000_0003);
        supply_uv <= 1'b1;
        cycles(3);
        chk({switching_active, discharge_on}, 32'h0000_0001);
        supply_uv <= 1'b0;
        en_pin <= 1'b0;
        cycles(3);
        chk(32'(discharge_on), 32'h0000_0001);
        bus(1, ADDR_CTRL1, 8'h22);
        cycles(2);
        chk(32'(discharge_on), 32'h0000_0000);
        bus(1, ADDR_CTRL1, 8'h32);
        en_pin <= 1'b1;
        wait_run(1'b1);
        // Supply overvoltage stops switching, restart follows its removal
        supply_ov <= 1'b1;
        cycles(3);
        chk({switching_active, discharge_on}, 32'h0000_0001);
        supply_ov <= 1'b0;
        wait_run(1'b1);
        thermal_shutdown <= 1'b1;
        cycles(3);
        chk({switching_active, discharge_on}, 32'h0000_0001);
        thermal_shutdown <= 1'b0;
        wait_run(1'b1);
    endtask

    task automatic scen_mode();
        logic signed [4:0] t0;
        mode_pwm_level <= 1'b1;
        cycles(3);
        chk(32'(forced_pwm), 32'h0000_0001);
        mode_pwm_level <= 1'b0;
        cycles(3);
        chk(32'(forced_pwm), 32'h0000_0000);
        bus(1, ADDR_CTRL1, 8'h3E);
        cycles(3);
        chk({forced_pwm, ssc_active}, 32'h0000_0003);
        // Exactly one switching cycle in four clocks moves the trim by one
        t0 = ssc_trim_pct;
        cycles(4);
        chk(32'((ssc_trim_pct - t0 == 5'sh01) || (t0 - ssc_trim_pct == 5'sh01)), 32'h0000_0001);
        sync_clock_valid <= 1'b1;
        cycles(3);
        chk({forced_pwm, sync_align, ssc_active}, 32'h0000_0006);
        sync_clock_valid <= 1'b0;
        bus(1, ADDR_CTRL1, 8'h32);
        cycles(3);
        chk({forced_pwm, ssc_active}, 32'h0000_0000);
        chk(32'(ssc_trim_pct), 32'h0000_0000);
    endtask

    task automatic scen_limit();
        overload <= 1'b1;
        cycles(30);
        chk({hs_gate_en, ls_force_on}, 32'h0000_0001);
        bus(0, ADDR_STATUS, 8'h00);
        chk(32'(q[1:0]), 32'h0000_0002);
        bus(0, ADDR_STATUS, 8'h00);
        chk(32'(q[1:0]), 32'h0000_0002);
        overload <= 1'b0;
        cycles(10);
        bus(0, ADDR_STATUS, 8'h00);
        bus(0, ADDR_STATUS, 8'h00);
        chk(32'(q[1:0]), 32'h0000_0000);
        chk(32'(hs_gate_en), 32'h0000_0001);
    endtask

    task automatic scen_retry();
        bus(1, ADDR_CTRL1, 8'h72);
        overload <= 1'b1;
        wait_run(1'b0);
        bus(0, ADDR_STATUS, 8'h00);
        chk(32'(q[1:0]), 32'h0000_0001);
        wait_run(1'b1);
        chk(32'(soft_start_req), 32'h0000_0001);
        wait_run(1'b0);
        overload <= 1'b0;
        cycles(30);
        bus(0, ADDR_STATUS, 8'h00);
        bus(0, ADDR_STATUS, 8'h00);
        chk(32'(q[0]), 32'h0000_0000);
    endtask

    initial
    begin
        forever #25 clock = ~clock;
    end

    initial
    begin
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        scen_regs();
        scen_discharge();
        scen_mode();
        scen_limit();
        scen_retry();
        conclude();
    end
endmodule
